//--- include/osf_if.sv
// Conversion control link between host and filter
`timescale 1ns/100ps
interface osf_if;
    logic [2:0] ratio_select_pins;               // Ratio, msb at bit 2
    logic       conversion_start_first_group;    // Start, channels 1 to 4
    logic       conversion_start_second_group;   // Start, channels 5 to 8
    logic       busy;                            // Conversion in progress
    logic [8*18-1:0] result;                     // Output data registers

    modport device (input ratio_select_pins, conversion_start_first_group,
                    conversion_start_second_group,
                    output busy, result);
    modport host   (output ratio_select_pins, conversion_start_first_group,
                    conversion_start_second_group,
                    input busy, result);
endinterface : osf_if

//--- include/osf_pkg.sv
// Shared constants and a helper function for the oversampling average filter link
package osf_pkg;
    localparam int          OSF_CHANNELS   = 8;      // Simultaneous channels
    localparam int          OSF_RES_W      = 18;     // Result width
    localparam int          OSF_RATIO_W    = 3;      // Ratio pin field width
    localparam logic [2:0]  OSF_RATIO_NONE = 3'h0;   // No oversampling
    localparam logic [2:0]  OSF_RATIO_MAX  = 3'h6;   // Ratio 64
    localparam logic [2:0]  OSF_RATIO_BAD  = 3'h7;   // Invalid code
    localparam logic [2:0]  OSF_RATIO_RST  = 3'h0;   // Ratio after reset
    localparam int          OSF_ACC_W      = OSF_RES_W + 6; // Sum of 64 samples
    // Internal sample strobe spacing and conversion time in mclk cycles
    localparam int          OSF_SAMPLE_CYC = 16;
    localparam int          OSF_CONV_CYC   = 16;
    // Host start period at ratio none: 200 kHz is 5 us, 1000 cycles at 5 ns
    localparam real         OSF_START_PERIOD_US = 5.0;
    localparam real         OSF_CLK_NS          = 5.0;
    localparam int          OSF_START_CYC =
        int'($ceil(OSF_START_PERIOD_US * 1000.0 / OSF_CLK_NS));
    localparam int          OSF_CNT_W      = 20;     // Host period counter

    // Ratio code to count of samples, invalid code treated as one sample
    function automatic logic [6:0] osf_samples(input logic [2:0] code);
        if (code > OSF_RATIO_MAX) begin
            return 7'h01;
        end
        return 7'(7'h01 << code);
    endfunction : osf_samples
endpackage : osf_pkg

//--- verif/osf_checker.sv
// Link checker for the oversampling filter control link
`timescale 1ns/100ps
module osf_checker
    import osf_pkg::*;
(
    input wire logic         mclk,                          // Clock
    input wire logic         resetn,                        // Reset, low
    input wire logic [2:0]   ratio_select_pins,             // Ratio code
    input wire logic         conversion_start_first_group,  // Start one
    input wire logic         conversion_start_second_group, // Start two
    input wire logic         busy,                          // Busy level
    input wire logic [143:0] result                         // Results
);
    logic [10:0] cnt_q;  // Busy cycles so far
    logic [2:0]  code_q; // Ratio in force
    logic [3:0]  age_q;  // Cycles since a start rise
    logic [10:0] len_w;  // Expected busy length
    assign len_w = ((code_q > 3'h6) ? 11'h1 : (11'h1 << code_q)) * 11'h10
                   + 11'h1;
    ////////////////////////////////////////////////////////////////////
    // Track ratio and busy length; one shared update keeps them aligned
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cnt_q  <= 11'h0;
            code_q <= 3'h0;
            age_q  <= 4'hF;
        end else begin
            cnt_q  <= busy ? cnt_q + 11'h1 : 11'h0;
            code_q <= $fell(busy) ? ratio_select_pins : code_q;
            age_q  <= $rose(conversion_start_first_group) ? 4'h0 :
                      (age_q == 4'hF) ? age_q : age_q + 4'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    a_result_hold: assert property (busy |-> $stable(result))
        else $error("result moved while busy");
    a_result_load: assert property (
        $changed(result) |-> $fell(busy))
        else $error("result moved outside busy fall");
    a_busy_min: assert property (
        $rose(busy) |-> busy[*8] ##1 busy[*8] ##1 busy)
        else $error("busy too short");
    a_busy_length: assert property (
        $fell(busy) |-> cnt_q == len_w)
        else $error("busy length not ratio based");
    a_busy_bound: assert property (cnt_q <= 11'h401)
        else $error("busy too long");
    a_start_pair: assert property (
        conversion_start_first_group == conversion_start_second_group)
        else $error("starts apart");
    a_start_answer: assert property (
        $rose(conversion_start_first_group) && !busy |-> ##[2:6] $rose(busy))
        else $error("no busy");
    a_busy_cause: assert property ($rose(busy) |-> age_q <= 4'h6)
        else $error("busy without start");
    c_top_ratio: cover property ($fell(busy) && code_q == 3'h6);
    c_bad_ratio: cover property ($fell(busy) && code_q == 3'h7);
    c_start: cover property ($rose(busy));
endmodule : osf_checker

//--- verif/osf_tb.sv
// Self-checking bench for the filter link, both ends
`timescale 1ns/100ps
module osf_tb
    import osf_pkg::*;
;
    logic               mclk = 1'b0;         // Clock
    logic               resetn = 1'b0;       // Reset, low
    logic [2:0]         ratio_req = 3'h7;    // Wanted ratio
    logic               run = 1'b0;          // Start enable
    logic [143:0]       sample_in, data_out, exp_v, exp_d;
    logic               sample_strobe, data_valid, busy_q = 1'b0;
    logic               st_q = 1'b0;         // Start level last cycle
    logic [143:0]       exp_q[$];            // Expected results
    logic signed [23:0] acc[8] = '{default: 24'h0};
    logic [2:0]         code_q = 3'h0;       // Ratio in force
    logic [6:0]         nstr = 7'h0;         // Strobes this conversion
    logic [3:0]         dly = 4'h0;          // Sample change delay
    logic [31:0]        seed = 32'hC9DF2CF5; // Random state
    int                 err_count = 0, total_checks = 0, cyc = 0;
    int                 gap = 0, per = 0;    // Start spacing, seen and due
    osf_if u_osf_if();
    osf_device u_osf_device(.mclk(mclk), .resetn(resetn), .link(u_osf_if),
        .sample_in(sample_in), .sample_strobe(sample_strobe));
    osf_host u_osf_host(.mclk(mclk), .resetn(resetn), .link(u_osf_if),
        .ratio_req(ratio_req), .run(run), .data_out(data_out),
        .data_valid(data_valid));
    osf_checker u_osf_checker(.mclk(mclk), .resetn(resetn),
        .ratio_select_pins(u_osf_if.ratio_select_pins),
        .conversion_start_first_group(u_osf_if.conversion_start_first_group),
        .conversion_start_second_group(u_osf_if.conversion_start_second_group),
        .busy(u_osf_if.busy), .result(u_osf_if.result));
    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic chk(input logic [143:0] s, e, input string n);
        total_checks++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////////
    // Clock, and a cycle ceiling above the 66k cycles of nine conversions
    initial forever #2.5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 80000) begin
            err_count++;
            test_done();
        end
    end
    // Samples change mid-gap only, so the strobe edge never races them
    always @(posedge mclk) if (dly == 4'h1) sample_in <= 144'({xs(), xs(),
        xs(), xs(), xs()});
    // Model on the falling edge, where the design outputs have settled
    always @(negedge mclk) begin
        dly = sample_strobe ? 4'h8 : (dly != 4'h0) ? dly - 4'h1 : dly;
        if (sample_strobe) begin
            nstr++;
            for (int c = 0; c < 8; c++)
                acc[c] += 24'(signed'(sample_in[c*18+:18]));
        end
        if (busy_q && !u_osf_if.busy) begin
            exp_v = (code_q > 3'h6) ? 144'h1 : 144'h1 << code_q;
            chk(144'(nstr), exp_v, "strobes");
            for (int c = 0; c < 8; c++) begin
                exp_v[c*18+:18] = 18'(acc[c] >>> ((code_q > 3'h6) ? 0 : code_q));
                acc[c] = 24'h0;
            end
            exp_q.push_back(exp_v);
            chk(u_osf_if.result, exp_v, "result");
            code_q = u_osf_if.ratio_select_pins;
            nstr = 7'h0;
        end
        busy_q = u_osf_if.busy;
    end
    // Host results against the oldest note
    always @(negedge mclk) if (data_valid) begin
        exp_d = exp_q.size() ? exp_q.pop_front() : 'x;
        chk(data_out, exp_d, "data");
    end
    // Start spacing must be the period of the ratio on the pins at the start
    always @(negedge mclk) begin
        gap++;
        if (u_osf_if.conversion_start_first_group && !st_q) begin
            if (per != 0) chk(144'(gap), 144'(per), "start gap");
            per = OSF_START_CYC << u_osf_if.ratio_select_pins;
            gap = 0;
        end
        st_q = u_osf_if.conversion_start_first_group;
    end
    ////////////////////////////////////////////////////////////////////
    // Invalid code first, then ratios 1 to 64 in rising order. Codes change
    // while busy, so each applies one conversion late, and the long host
    // period of the top ratio is never waited out
    initial begin
        sample_in = 144'({xs(), xs(), xs(), xs(), xs()});
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        run <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            @(posedge u_osf_if.busy);
            if (i > 0 && i < 8) ratio_req <= 3'(i - 1);
            @(posedge data_valid);
        end
        run <= 1'b0;
        test_done();
    end
endmodule : osf_tb

//--- verilog/osf_device.sv
// Oversampling averaging filter, device end
// Notes on behaviour
// - Ratio field from three pins, msb first
// - 000 none, 001-110 ratios 2..64, 111 invalid
// - Ratio latched at busy fall, used next
// - First sample at start, rest internally strobed
// - Average N samples per channel
// - Averaged result decimated to 18 bits
// - Host drives both start inputs together
// - Busy spans whole oversampled conversion
// - Output registers load at busy fall
// - Host avoids reading at busy fall
// - Previous results readable while busy high
// - Host start rate halves per ratio step
`timescale 1ns/100ps
module osf_device
    import osf_pkg::*;
#(
    parameter int CH  = OSF_CHANNELS,        // Channel count
    parameter int RES = OSF_RES_W            // Sample width
)(
    input  wire logic           mclk,         // System clock
    input  wire logic           resetn,       // Async reset, active low
    osf_if.device               link,         // Control link
    input  wire logic [CH*RES-1:0] sample_in, // Converter samples, signed
    output logic                sample_strobe // Converter sample taken
);
    typedef enum logic [1:0] {
        OSF_IDLE = 2'b00,
        OSF_CONV = 2'b01,
        OSF_DONE = 2'b10
    } osf_state_t;

    typedef struct packed {
        logic [1:0]         s1_start;   // Synchroniser first stage
        logic [1:0]         s2_start;   // Synchroniser second stage
        logic [1:0]         start_prev; // Edge detect
        logic [2:0]         r1;         // Ratio pins first stage
        logic [2:0]         r2;         // Ratio pins second stage
        logic [2:0]         ratio;      // Latched ratio
        osf_state_t         st;
        logic [6:0]         left;       // Samples still to take
        logic [7:0]         tick;       // Strobe spacing counter
        logic               busy;
        logic               strobe;
        logic [CH*OSF_ACC_W-1:0] acc;
        logic [CH*RES-1:0]  result;
    } osf_dev_t;

    osf_dev_t q, d;

    // Sign-extended add of one sample to one accumulator
    function automatic logic [OSF_ACC_W-1:0] acc_add(
        input logic [OSF_ACC_W-1:0] a, input logic [RES-1:0] s);
        return a + OSF_ACC_W'({{(OSF_ACC_W-RES){s[RES-1]}}, s});
    endfunction : acc_add

    // Conversion sequencer; pins pass two flops before use
    always_comb begin
        logic start_rise;
        logic [6:0] n;
        start_rise = 1'b0;
        n = 7'h01;
        d = q;
        d.s1_start = {link.conversion_start_second_group,
                      link.conversion_start_first_group};
        d.s2_start = q.s1_start;
        d.start_prev = q.s2_start;
        d.r1 = link.ratio_select_pins;
        d.r2 = q.r1;
        d.strobe = 1'b0;
        // Either group starts all; host ties them together
        start_rise = |(q.s2_start & ~q.start_prev);
        n = osf_samples(q.ratio);
        unique case (q.st)
            OSF_IDLE: begin
                if (start_rise) begin
                    d.st = OSF_CONV;
                    d.busy = 1'b1;
                    d.strobe = 1'b1;
                    d.left = n - 7'h01;
                    d.tick = 8'(OSF_SAMPLE_CYC - 1);
                    for (int c = 0; c < CH; c++) begin
                        d.acc[c*OSF_ACC_W +: OSF_ACC_W] =
                            acc_add('0, sample_in[c*RES +: RES]);
                    end
                end
            end
            OSF_CONV: begin
                // Busy stays high until every sample is
                if (q.tick != 8'h00) begin
                    d.tick = q.tick - 8'h01;
                end else if (q.left != 7'h00) begin
                    d.strobe = 1'b1;
                    d.left = q.left - 7'h01;
                    d.tick = 8'(OSF_SAMPLE_CYC - 1);
                    for (int c = 0; c < CH; c++) begin
                        d.acc[c*OSF_ACC_W +: OSF_ACC_W] = acc_add(
                            q.acc[c*OSF_ACC_W +: OSF_ACC_W],
                            sample_in[c*RES +: RES]);
                    end
                end else begin
                    d.st = OSF_DONE;
                end
            end
            OSF_DONE: begin
                // Busy fall: results load, ratio latched for next
                d.st = OSF_IDLE;
                d.busy = 1'b0;
                d.ratio = q.r2;
                for (int c = 0; c < CH; c++) begin
                    // Arithmetic shift by log2 N divides and keeps 18 bits
                    d.result[c*RES +: RES] = RES'($signed(
                        q.acc[c*OSF_ACC_W +: OSF_ACC_W]) >>>
                        ((q.ratio > OSF_RATIO_MAX) ? 3'h0 : q.ratio));
                end
            end
            default: begin
                d.st = OSF_IDLE;
                d.busy = 1'b0;
            end
        endcase
    end

    // State register
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
            q.ratio <= OSF_RATIO_RST;
        end else begin
            q <= d;
        end
    end

    // Result held through busy, old data readable meanwhile
    assign link.busy = q.busy;
    assign link.result = q.result;
    assign sample_strobe = q.strobe;
endmodule : osf_device

//--- verilog/osf_host.sv
// Conversion control host end
`timescale 1ns/100ps
module osf_host
    import osf_pkg::*;
#(
    parameter int CH = OSF_CHANNELS,       // Channel count
    parameter int RES = OSF_RES_W          // Result width
)(
    input  wire logic           mclk,        // System clock
    input  wire logic           resetn,      // Async reset, active low
    osf_if.host                 link,        // Control link
    input  wire logic [2:0]     ratio_req,   // Wanted ratio code
    input  wire logic           run,         // Enable periodic starts
    output logic [CH*RES-1:0]   data_out,    // Last captured results
    output logic                data_valid   // One-cycle new data pulse
);
    typedef struct packed {
        logic [2:0]           ratio;
        logic                 start;
        logic [OSF_CNT_W-1:0] cnt;
        logic                 b1;
        logic                 b2;
        logic                 b3;
        logic                 wait_rd;    // Set three cycles after busy fall; result read on the next edge
        logic [CH*RES-1:0]    data;
        logic                 valid;
    } osf_host_t;

    osf_host_t q, d;

    // Start pacing and result capture
    always_comb begin
        logic [OSF_CNT_W-1:0] period;
        period = '0;
        d = q;
        d.b1 = link.busy;
        d.b2 = q.b1;
        d.b3 = q.b2;
        d.valid = 1'b0;
        d.wait_rd = 1'b0;
        // Never present the invalid code
        d.ratio = (ratio_req == OSF_RATIO_BAD) ? OSF_RATIO_NONE : ratio_req;
        // Period doubles per ratio step
        period = OSF_CNT_W'(OSF_START_CYC) << q.ratio;
        if (q.cnt != '0) begin
            d.cnt = q.cnt - 1'b1;
        end else if (run) begin
            d.cnt = period - 1'b1;
        end
        // Start high for the first half of each period
        d.start = run && (q.cnt > (period >> 1));
        // Sample results after busy fall, never on it
        if (q.b3 && !q.b2) begin
            d.wait_rd = 1'b1;
        end
        if (q.wait_rd) begin
            d.data = link.result;
            d.valid = 1'b1;
        end
    end

    // State register
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Both start groups driven together
    assign link.conversion_start_first_group  = q.start;
    assign link.conversion_start_second_group = q.start;
    assign link.ratio_select_pins = q.ratio;
    assign data_out   = q.data;
    assign data_valid = q.valid;
endmodule : osf_host
